/* File: rtl/spc_pkg.sv */
// Constants for the daisy-chain serial control port host controller
// Operation
// R1: Broadcast flag is control bit 7; broadcast is allowed for writes only.
// R2: Control bit 6 is direction: 1 is read, 0 is write.
// R3: Control bit 5 is always one, bit 4 always zero.
// R4: Control bits 3..0 hold chain_channel_id, least significant bit first.
// R5: Chain position 0 is nearest the controller, 15 farthest.
// R6: Each device forwards the id minus one; id zero executes.
// R7: Broadcast forwards the id unchanged; every device takes the write data.
// R8: Broadcast and direction flags pass down the chain unaltered.
// R9: Eight-bit mode: three bytes, chip select toggled between bytes.
// R10: Eight-bit mode: chip select rises before the falling edge after data.
// R11: Device ignores its data input during the data byte of a read.
// R12: Sixteen-bit mode: four bytes as two words, select held after bit eight.
// R13: Sixteen-bit write: device discards the eight bits after the data byte.
// R14: Sixteen-bit read: data byte is sent twice; second copy is usable.
// R15: Device detects eight- or sixteen-bit transfers by itself.
// R16: Highway mode turns pass-through, data-out and select into straps.
// R17: Subframe is seven minus strap value, pass-through msb, select lsb.
// R18: Straps stay fixed during operation; no register selects the subframe.
// R19: At most one device per subframe, eight devices per highway.
// R20: Highway bit clock is 2.048 or 4.096 MHz, detected automatically; the code divides 25 MHz to about 2.083 or 4.167 MHz.
// R21: An 8 kHz frame_sync rising edge starts each 125 us frame.
// R22: A frame holds eight subframes of four bytes each.
// R23: Select change off a multiple of eight clocks resets the device port.
// R24: Bytes go most significant bit first; only six address bits count.
// R25: A device that is not the read target leaves its output undriven.
`default_nettype none
package spc_pkg;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_ADDR = 4'h4;
	localparam logic [3:0] OFS_WDATA = 4'h8;
	localparam logic [3:0] OFS_STAT = 4'hc;
	localparam int CB_START = 0;
	localparam int CB_RW = 1;
	localparam int CB_BCAST = 2;
	localparam int CB_ID_LO = 4;
	localparam int CB_WIDE = 8;
	localparam int CB_HWY = 9;
	localparam int CB_SF_LO = 10;
	localparam int CB_HW2X = 13;
	localparam int SB_BUSY = 0;
	localparam int SB_DONE = 1;
	localparam int SB_ERR = 2;
	localparam int SB_RD_LO = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [5:0] ADDR_RST = 6'h00;
	localparam logic [7:0] WDATA_RST = 8'h00;
	localparam logic [1:0] CTL_FIXED = 2'h2;
	localparam logic [7:0] PAD_BYTE = 8'h00;
	localparam logic [2:0] STRAP_TOP = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SCLK_HALF_CYC = 4;
	localparam int CLK_NS = 40;
	localparam int CLK_KHZ = 25000;
	localparam int FRAME_NS = 125000;
	localparam int FRAME_CYC = FRAME_NS / CLK_NS;
	localparam int HWY_1X_KHZ = 2048;
	localparam int HWY_2X_KHZ = 4096;
	localparam int HWY_1X_HALF = CLK_KHZ / (2 * HWY_1X_KHZ);
	localparam int HWY_2X_HALF = CLK_KHZ / (2 * HWY_2X_KHZ);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_GAP   = 3'b100
	} spc_state_type;
endpackage : spc_pkg
`default_nettype wire

/* File: rtl/spc_shifter.sv */
// One-byte serial shifter with idle-high clock and msb-first data
`default_nettype none
module spc_shifter #(
	parameter int HALF = 4
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	input  wire logic       miso_s,
	output logic            done,
	output logic [7:0]      rx_byte,
	output logic            sclk,
	output logic            mosi,
	output logic            busy
);
	logic [7:0] sh_r;
	logic [7:0] tmr_r;
	logic [2:0] bit_r;

	assign rx_byte = sh_r;

	always_ff @(posedge clk)
	begin
		done <= 1'b0;
		if (sys_rst)
		begin
			busy  <= 1'b0;
			sclk  <= 1'b1;
			mosi  <= 1'b0;
			sh_r  <= 8'h00;
			tmr_r <= 8'h00;
			bit_r <= 3'h0;
		end
		else if (start && !busy)
		begin
			busy  <= 1'b1;
			sh_r  <= tx_byte;
			tmr_r <= 8'h00;
			bit_r <= 3'h0;
		end
		else if (busy)
		begin
			if (tmr_r == 8'(HALF - 1))
			begin
				tmr_r <= 8'h00;
				if (sclk)
				begin
					sclk <= 1'b0;
					mosi <= sh_r[7]; // [R24]
				end
				else
				begin
					// Sample on rising edge; device shifts on falling
					sclk  <= 1'b1;
					sh_r  <= {sh_r[6:0], miso_s}; // [R24]
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7)
					begin
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
			end
			else
				tmr_r <= tmr_r + 8'h01;
		end
	end
endmodule : spc_shifter
`default_nettype wire

/* File: rtl/spc_ctrl.sv */
// Host controller for the daisy-chain serial control port
`default_nettype none
module spc_ctrl #(
	parameter int SCLK_HALF = spc_pkg::SCLK_HALF_CYC,
	parameter int FRAME     = spc_pkg::FRAME_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             sclk,
	output logic             cs_n,
	output logic             mosi,
	output logic             mosi_oe,
	input  wire logic        miso,
	output logic             passthrough_strap,
	output logic             passthrough_strap_oe,
	output logic             data_out_strap,
	output logic             data_out_strap_oe,
	output logic             frame_sync,
	output logic             highway_clk
);
	spc_pkg::spc_state_type state_r;
	logic        rw_r;
	logic        bcast_r;
	logic [3:0]  id_r;
	logic        wide_r;
	logic        hwy_r;
	logic        hw2x_r;
	logic [2:0]  sf_r;
	logic [2:0]  strap_r;
	logic [5:0]  addr_r;
	logic [7:0]  wdata_r;
	logic [7:0]  rdata_r;
	logic        done_r;
	logic        err_r;
	logic        cs_r;
	logic [1:0]  idx_r;
	logic        fin_r;
	logic        sh_start_r;
	logic [7:0]  gap_r;
	logic        miso_m_r;
	logic        miso_s_r;
	logic [15:0] frame_r;
	logic [7:0]  hclk_r;
	logic        hclk_q_r;
	logic        fs_r;
	logic        wr_fire;
	logic        ctrl_wr;
	logic        stat_wr;
	logic        go;
	logic        bad_go;
	logic        sh_done;
	logic        sh_sclk;
	logic        sh_mosi;
	logic [7:0]  sh_rx;
	logic [7:0]  tx_byte;
	logic [1:0]  last_idx;
	logic        busy;
	logic [7:0]  hhalf;

	// Chain id goes out lsb first, so its bits are mirrored
	function automatic logic [7:0] ctl_byte(input logic b, input logic r,
		input logic [3:0] id);
		ctl_byte = {b, r, spc_pkg::CTL_FIXED,
			id[0], id[1], id[2], id[3]}; // [R1] [R2] [R3] [R4]
	endfunction : ctl_byte

	assign busy = (state_r != spc_pkg::ST_IDLE);

	// AXI4-Lite write channel: address and data taken together
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign ctrl_wr = wr_fire && s_axi_awaddr == spc_pkg::OFS_CTRL
		&& s_axi_wstrb[0] && s_axi_wstrb[1];
	assign stat_wr = wr_fire && s_axi_awaddr == spc_pkg::OFS_STAT
		&& s_axi_wstrb[0];
	assign go = ctrl_wr && s_axi_wdata[spc_pkg::CB_START] && !busy
		&& !s_axi_wdata[spc_pkg::CB_HWY] && !hwy_r;
	// Broadcast read would make every device drive at once
	assign bad_go = go && s_axi_wdata[spc_pkg::CB_RW]
		&& s_axi_wdata[spc_pkg::CB_BCAST]; // [R1]

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= spc_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (s_axi_awaddr == spc_pkg::OFS_CTRL
				|| s_axi_awaddr == spc_pkg::OFS_ADDR
				|| s_axi_awaddr == spc_pkg::OFS_WDATA
				|| s_axi_awaddr == spc_pkg::OFS_STAT)
				? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Configuration registers; ignored while a transfer runs
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rw_r    <= spc_pkg::CTRL_RST[spc_pkg::CB_RW];
			bcast_r <= spc_pkg::CTRL_RST[spc_pkg::CB_BCAST];
			id_r    <= spc_pkg::CTRL_RST[spc_pkg::CB_ID_LO +: 4];
			wide_r  <= spc_pkg::CTRL_RST[spc_pkg::CB_WIDE];
			hwy_r   <= spc_pkg::CTRL_RST[spc_pkg::CB_HWY];
			hw2x_r  <= spc_pkg::CTRL_RST[spc_pkg::CB_HW2X];
			sf_r    <= spc_pkg::CTRL_RST[spc_pkg::CB_SF_LO +: 3];
			addr_r  <= spc_pkg::ADDR_RST;
			wdata_r <= spc_pkg::WDATA_RST;
		end
		else
		begin
			if (ctrl_wr && !busy)
			begin
				rw_r    <= s_axi_wdata[spc_pkg::CB_RW];
				bcast_r <= s_axi_wdata[spc_pkg::CB_BCAST];
				id_r    <= s_axi_wdata[spc_pkg::CB_ID_LO +: 4]; // [R5]
				wide_r  <= s_axi_wdata[spc_pkg::CB_WIDE];
				hwy_r   <= s_axi_wdata[spc_pkg::CB_HWY];
				hw2x_r  <= s_axi_wdata[spc_pkg::CB_HW2X];
				if (!hwy_r)
					sf_r <= s_axi_wdata[spc_pkg::CB_SF_LO +: 3]; // [R18]
			end
			if (wr_fire && s_axi_awaddr == spc_pkg::OFS_ADDR
				&& s_axi_wstrb[0] && !busy)
				addr_r <= s_axi_wdata[5:0]; // [R24]
			if (wr_fire && s_axi_awaddr == spc_pkg::OFS_WDATA
				&& s_axi_wstrb[0] && !busy)
				wdata_r <= s_axi_wdata[7:0];
		end
	end

	// Strap value frozen while highway mode is on
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			strap_r <= spc_pkg::STRAP_TOP;
		else if (ctrl_wr && !busy && !hwy_r)
			// Loaded from the written subframe, not one write late
			strap_r <= spc_pkg::STRAP_TOP
				- s_axi_wdata[spc_pkg::CB_SF_LO +: 3]; // [R17] [R18] [R19]
	end

	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= spc_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= spc_pkg::RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			case (s_axi_araddr)
				spc_pkg::OFS_CTRL:
				begin
					s_axi_rdata[spc_pkg::CB_RW]         <= rw_r;
					s_axi_rdata[spc_pkg::CB_BCAST]      <= bcast_r;
					s_axi_rdata[spc_pkg::CB_ID_LO +: 4] <= id_r;
					s_axi_rdata[spc_pkg::CB_WIDE]       <= wide_r;
					s_axi_rdata[spc_pkg::CB_HWY]        <= hwy_r;
					s_axi_rdata[spc_pkg::CB_SF_LO +: 3] <= sf_r;
					s_axi_rdata[spc_pkg::CB_HW2X]       <= hw2x_r;
				end
				spc_pkg::OFS_ADDR:
					s_axi_rdata[5:0] <= addr_r;
				spc_pkg::OFS_WDATA:
					s_axi_rdata[7:0] <= wdata_r;
				spc_pkg::OFS_STAT:
				begin
					s_axi_rdata[spc_pkg::SB_BUSY]       <= busy;
					s_axi_rdata[spc_pkg::SB_DONE]       <= done_r;
					s_axi_rdata[spc_pkg::SB_ERR]        <= err_r;
					s_axi_rdata[spc_pkg::SB_RD_LO +: 8] <= rdata_r;
				end
				default:
					s_axi_rresp <= spc_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Returned byte is fed straight from a two-stage synchroniser
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			miso_m_r <= 1'b0;
			miso_s_r <= 1'b0;
		end
		else
		begin
			miso_m_r <= miso;
			miso_s_r <= miso_m_r;
		end
	end

	// Byte sequence: control, address, data, then pad in wide mode
	always_comb
	begin
		case (idx_r)
			2'h0: tx_byte = ctl_byte(bcast_r, rw_r, id_r);
			2'h1: tx_byte = {2'h0, addr_r}; // [R24]
			2'h2: tx_byte = rw_r ? spc_pkg::PAD_BYTE : wdata_r;
			default: tx_byte = spc_pkg::PAD_BYTE; // [R13]
		endcase
	end
	assign last_idx = wide_r ? 2'h3 : 2'h2; // [R9] [R12]

	always_ff @(posedge clk)
	begin
		sh_start_r <= 1'b0;
		if (sys_rst)
		begin
			state_r <= spc_pkg::ST_IDLE;
			cs_r    <= 1'b1;
			idx_r   <= 2'h0;
			fin_r   <= 1'b0;
			gap_r   <= 8'h00;
		end
		else
		begin
			case (state_r)
				spc_pkg::ST_IDLE:
				begin
					if (go && !bad_go)
					begin
						state_r    <= spc_pkg::ST_SHIFT;
						cs_r       <= 1'b0;
						idx_r      <= 2'h0;
						fin_r      <= 1'b0;
						sh_start_r <= 1'b1;
					end
				end
				spc_pkg::ST_SHIFT:
				begin
					if (sh_done)
					begin
						gap_r <= 8'h00;
						if (idx_r == last_idx)
						begin
							// Select rises before any further clock edge
							cs_r    <= 1'b1; // [R10]
							fin_r   <= 1'b1;
							state_r <= spc_pkg::ST_GAP;
						end
						else if (!wide_r || idx_r == 2'h1)
						begin
							cs_r    <= 1'b1; // [R9] [R12]
							idx_r   <= idx_r + 2'h1;
							state_r <= spc_pkg::ST_GAP;
						end
						else
						begin
							// Wide mode keeps select low between the two bytes of a word
							idx_r      <= idx_r + 2'h1; // [R12]
							sh_start_r <= 1'b1;
						end
					end
				end
				spc_pkg::ST_GAP:
				begin
					if (gap_r == 8'(2 * SCLK_HALF - 1))
					begin
						if (fin_r)
							state_r <= spc_pkg::ST_IDLE;
						else
						begin
							cs_r       <= 1'b0;
							sh_start_r <= 1'b1;
							state_r    <= spc_pkg::ST_SHIFT;
						end
					end
					else
						gap_r <= gap_r + 8'h01;
				end
				default:
					state_r <= spc_pkg::ST_IDLE;
			endcase
		end
	end

	// Status: set wins over a write-one clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			done_r  <= 1'b0;
			err_r   <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			if (state_r == spc_pkg::ST_GAP && fin_r
				&& gap_r == 8'(2 * SCLK_HALF - 1))
				done_r <= 1'b1;
			else if (stat_wr && s_axi_wdata[spc_pkg::SB_DONE])
				done_r <= 1'b0;
			if (bad_go)
				err_r <= 1'b1; // [R1]
			else if (stat_wr && s_axi_wdata[spc_pkg::SB_ERR])
				err_r <= 1'b0;
			// Wide reads keep the second copy of the byte
			if (sh_done && rw_r && idx_r == last_idx)
				rdata_r <= sh_rx; // [R14]
		end
	end

	spc_shifter #(
		.HALF(SCLK_HALF)
	) u_shift (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (sh_start_r),
		.tx_byte (tx_byte),
		.miso_s  (miso_s_r),
		.done    (sh_done),
		.rx_byte (sh_rx),
		.sclk    (sh_sclk),
		.mosi    (sh_mosi),
		.busy    ()
	);

	// Highway frame timing; bit clock is not locked to the frame
	assign hhalf = hw2x_r ? 8'(spc_pkg::HWY_2X_HALF)
		: 8'(spc_pkg::HWY_1X_HALF);
	always_ff @(posedge clk)
	begin
		if (sys_rst || !hwy_r)
		begin
			frame_r  <= 16'h0000;
			fs_r     <= 1'b0;
			hclk_r   <= 8'h00;
			hclk_q_r <= 1'b0;
		end
		else
		begin
			fs_r <= (frame_r == 16'h0000); // [R21] [R22]
			if (frame_r == 16'(FRAME - 1))
				frame_r <= 16'h0000;
			else
				frame_r <= frame_r + 16'h0001;
			if (hclk_r == hhalf - 8'h01)
			begin
				hclk_r   <= 8'h00;
				hclk_q_r <= !hclk_q_r; // [R20]
			end
			else
				hclk_r <= hclk_r + 8'h01;
		end
	end
	assign frame_sync = fs_r;
	assign highway_clk = hclk_q_r;

	// Highway mode turns the port pins into fixed straps
	assign cs_n = hwy_r ? strap_r[0] : cs_r; // [R16] [R17]
	assign passthrough_strap = strap_r[2]; // [R17]
	assign passthrough_strap_oe = hwy_r; // [R16]
	assign data_out_strap = strap_r[1]; // [R17]
	assign data_out_strap_oe = hwy_r; // [R16]
	assign sclk = hwy_r ? 1'b1 : sh_sclk;
	assign mosi = sh_mosi;
	// Released during read data so the line may be shared
	assign mosi_oe = !hwy_r && !cs_r
		&& !(rw_r && idx_r[1]); // [R11]
endmodule : spc_ctrl
`default_nettype wire

/* File: sim/spc_ctrl_checker.sv */
// Assertions on the serial control port host controller
`default_nettype none
module spc_ctrl_checker #(
	parameter int SCLK_HALF = 4,
	parameter int FRAME     = 3125
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic mosi_oe,
	input wire logic passthrough_strap,
	input wire logic passthrough_strap_oe,
	input wire logic data_out_strap,
	input wire logic frame_sync
);
	logic [15:0] lo_r, gap_r, fs_r;
	logic        seen_r;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk)
		if (sys_rst || sclk)
			lo_r <= 16'h0;
		else
			lo_r <= lo_r + 16'h1;
	// Saturates so a long idle never wraps into a short gap
	always_ff @(posedge clk)
		if (sys_rst)
			gap_r <= 16'hffff;
		else if (!cs_n)
			gap_r <= 16'h0;
		else if (gap_r != 16'hffff)
			gap_r <= gap_r + 16'h1;
	always_ff @(posedge clk)
		if (sys_rst || frame_sync)
			fs_r <= 16'h0;
		else
			fs_r <= fs_r + 16'h1;
	always_ff @(posedge clk)
		if (sys_rst || !passthrough_strap_oe)
			seen_r <= 1'b0;
		else if (frame_sync)
			seen_r <= 1'b1;
	sequence s_hwy_held;
		passthrough_strap_oe ##1 passthrough_strap_oe;
	endsequence
	sequence s_pulse;
		frame_sync ##1 !frame_sync;
	endsequence
	AST_RST_IDLE: assert property ($fell(sys_rst) |-> cs_n && sclk
		&& !mosi_oe && !passthrough_strap_oe && !frame_sync)
		else $error("port not idle after reset");
	AST_SCLK_LOW: assert property ($rose(sclk) && !cs_n
		|-> lo_r == 16'(SCLK_HALF))
		else $error("serial clock low phase length wrong");
	AST_MOSI_HOLD: assert property ($rose(sclk) && !cs_n
		|-> $stable(mosi))
		else $error("data changed on rising serial clock");
	AST_CS_IDLE: assert property (cs_n |-> sclk)
		else $error("serial clock low while deselected");
	AST_CS_GAP: assert property ($fell(cs_n)
		|-> gap_r >= 16'(2 * SCLK_HALF))
		else $error("select gap too short");
	AST_STRAP_HOLD: assert property (s_hwy_held
		|-> $stable({passthrough_strap, data_out_strap, cs_n}))
		else $error("strap changed in highway mode");
	AST_HWY_QUIET: assert property (passthrough_strap_oe
		|-> sclk && !mosi_oe)
		else $error("serial port active in highway mode");
	AST_FRAME_PULSE: assert property (frame_sync |-> s_pulse)
		else $error("frame sync pulse too long");
	AST_FRAME_PERIOD: assert property (frame_sync && seen_r
		|-> fs_r == 16'(FRAME - 1))
		else $error("frame period wrong");
	AST_FRAME_HWY: assert property (frame_sync
		|-> passthrough_strap_oe)
		else $error("frame sync outside highway mode");
endmodule : spc_ctrl_checker
bind spc_ctrl spc_ctrl_checker #(.SCLK_HALF(SCLK_HALF), .FRAME(FRAME))
	chk_u (.*);
`default_nettype wire

/* File: sim/spc_dev_model.sv */
// Behavioural chained device on the serial control port
`default_nettype none
module spc_dev_model #(
	parameter logic [3:0] POS = 4'h0
) (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic     miso,
	output logic     miso_oe
);
	logic [7:0] mem [64];
	logic [7:0] sh, ctl, adr, ctl_last;
	logic [5:0] nb;
	logic [4:0] bw;
	logic       wide, hit;
	int         bad;
	// Decrement along the chain folded into the position
	assign hit = ctl[7]
		|| ({ctl[0], ctl[1], ctl[2], ctl[3]} == POS);
	initial
	begin
		{nb, bw, wide, miso, miso_oe} = '0;
		bad = 0;
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	always @(posedge sclk)
		if (!cs_n)
		begin
			sh = {sh[6:0], mosi};
			nb = nb + 6'h1;
			bw = bw + 5'h1;
			if (bw == 5'h9)
				wide = 1'b1;
			if (nb == 6'h8)
			begin
				ctl = sh;
				ctl_last = sh;
				if (sh[5:4] != 2'b10 || sh[7:6] == 2'b11)
					bad++;
			end
			if (nb == 6'h10)
				adr = sh;
			if (nb == 6'h18 && !ctl[6] && hit)
				mem[adr[5:0]] = sh;
			if (nb == 6'h20 || (nb == 6'h18 && !wide))
			begin
				nb = 6'h0;
				wide = 1'b0;
			end
		end
	always @(negedge sclk)
		if (!cs_n && nb >= 6'h10 && ctl[6] && hit)
		begin
			miso_oe = 1'b1;
			miso = mem[adr[5:0]][~nb[2:0]];
		end
	always @(posedge cs_n)
	begin
		if (bw[2:0] != 3'h0)
		begin
			nb = 6'h0;
			wide = 1'b0;
		end
		bw = 5'h0;
		if (miso_oe)
			miso = ~miso;
		miso_oe = 1'b0;
	end
endmodule : spc_dev_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the serial control port host controller
`default_nettype none
`define CHK(n, x, y) begin num_checks++; if ((y) !== (x)) begin \
	err_count++; $display("[FAIL] %s exp %0h got %0h", n, x, y); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FR = 50;
	localparam logic [3:0] CT = spc_pkg::OFS_CTRL;
	localparam logic [3:0] ST = spc_pkg::OFS_STAT;
	typedef struct packed {
		logic rw, bc, wd;
		logic [3:0] id;
		logic [5:0] a;
		logic [7:0] d;
	} spc_row_type;
	logic        clk, sys_rst, sclk, cs_n, mosi, mosi_oe, miso;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, frame_sync, highway_clk;
	logic        passthrough_strap, passthrough_strap_oe;
	logic        data_out_strap, data_out_strap_oe, q0, q1, oe0, oe1, hp;
	logic [2:0]  sf;
	int          err_count, num_checks, nf, nh, ne;
	spc_row_type rows [7] = '{
		'{1'b0, 1'b0, 1'b0, 4'h0, 6'h15, 8'ha5},
		'{1'b1, 1'b0, 1'b0, 4'h0, 6'h15, 8'ha5},
		'{1'b0, 1'b0, 1'b1, 4'h1, 6'h3f, 8'h3c},
		'{1'b1, 1'b0, 1'b1, 4'h1, 6'h3f, 8'h3c},
		'{1'b0, 1'b1, 1'b0, 4'h3, 6'h02, 8'h5a},
		'{1'b0, 1'b0, 1'b1, 4'h0, 6'h15, 8'hc3},
		'{1'b1, 1'b0, 1'b0, 4'h0, 6'h15, 8'hc3}};
	spc_ctrl #(.SCLK_HALF(4), .FRAME(FR)) dut_u (.*);
	spc_dev_model #(.POS(4'h0)) d0 (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(q0), .miso_oe(oe0));
	spc_dev_model #(.POS(4'h1)) d1 (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(q1), .miso_oe(oe1));
	// No pull on the data-out line: released level is the inverse of q0
	assign miso = oe0 ? q0 : (oe1 ? q1 : ~q0);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do @(negedge clk); while (!s_axi_awready);
		@(posedge clk);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		do @(negedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic do_row(input spc_row_type w);
		wr(spc_pkg::OFS_ADDR, {26'h0, w.a});
		if (!w.rw)
			wr(spc_pkg::OFS_WDATA, {24'h0, w.d});
		wr(CT, {23'h0, w.wd, w.id, 1'b0, w.bc, w.rw, 1'b1});
		v = 32'h0;
		repeat (300)
			if (!v[1])
				rd(ST, v);
		`CHK("stat", 3'h2, v[2:0]);
		if (w.rw)
			`CHK("rd_byte", w.d, v[15:8]);
		`CHK("ctl_byte", {w.bc, w.rw, 2'b10, w.id[0], w.id[1], w.id[2],
			w.id[3]}, d0.ctl_last);
		wr(ST, 32'h2);
	endtask : do_row
	initial
	begin
		repeat (30000) @(posedge clk);
		err_count++;
		$display("watchdog expired");
		finish_test();
	end
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, hp} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		sys_rst = 1'b1;
		err_count = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rd(4'(4 * i), v);
			`CHK("rst_reg", 34'h0, {r, v});
		end
		rd(4'h2, v);
		`CHK("unmapped_rd", {spc_pkg::RESP_SLVERR, 32'h0}, {r, v});
		wr(4'h6, 32'h1);
		`CHK("unmapped_wr", spc_pkg::RESP_SLVERR, r);
		$display("register test done");
		foreach (rows[i])
		begin
			do_row(rows[i]);
			$display("row %0d done", i);
		end
		`CHK("target_mem", 8'hc3, d0.mem[6'h15]);
		`CHK("other_mem", 16'h0, {d1.mem[6'h15], d0.mem[6'h3f]});
		`CHK("bcast_mem", 8'h5a, d1.mem[6'h02]);
		`CHK("ctl_rules", 0, d0.bad + d1.bad);
		wr(CT, 32'h7);
		rd(ST, v);
		`CHK("bc_read", 2'b10, {v[2], v[0]});
		`CHK("no_xfer", 8'h60, d0.ctl_last);
		wr(ST, 32'h4);
		$display("broadcast read test done");
		wr(CT, 32'h1);
		repeat (20) @(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		`CHK("rst_pins", 2'h3, {cs_n, sclk});
		rd(CT, v);
		`CHK("rst_ctrl", spc_pkg::CTRL_RST, v);
		do_row(rows[6]);
		$display("abort test done");
		for (int k = 0; k < 2; k++)
		begin
			sf = k ? 3'h2 : 3'h5;
			wr(CT, {18'h0, k[0], sf, 1'b1, 9'h0});
			repeat (FR) @(posedge clk);
			`CHK("strap", 3'h7 - sf, {passthrough_strap,
				data_out_strap, cs_n});
			`CHK("strap_oe", 3'h6, {passthrough_strap_oe,
				data_out_strap_oe, mosi_oe});
			{nf, nh} = '0;
			hp = highway_clk;
			repeat (5 * FR)
			begin
				@(negedge clk);
				nf += frame_sync;
				nh += highway_clk & !hp;
				hp = highway_clk;
			end
			ne = 5 * FR / (2 * (k ? spc_pkg::HWY_2X_HALF
				: spc_pkg::HWY_1X_HALF));
			`CHK("frames", 5, nf);
			`CHK("bit_clk", 1'b1, nh == ne || nh == ne + 1);
			wr(CT, 32'h0);
			$display("highway test %0d done", k);
		end
		finish_test();
	end
endmodule : tb
`default_nettype wire
